/* ifeb_pkg.sv */
/*
 * Constants, register map and field positions of the interrupt flag and
 * enable bank, plus the one-register storage cell it is built from.
 * Assumes a single system clock and an asynchronous active-low reset.
 */
`timescale 1ns/10ps
`default_nettype none

// ============================================================
// Package
// ============================================================
package ifeb_pkg;

	// Register byte offsets on the AHB-Lite slave
	localparam logic [11:0] FLAG_STATUS_SIX_OFS     = 12'h000;
	localparam logic [11:0] FLAG_STATUS_SEVEN_OFS   = 12'h004;
	localparam logic [11:0] ENABLE_CONTROL_ZERO_OFS = 12'h008;
	localparam int          ADDR_W                  = 12;

	// Value of every register after power-on reset
	localparam logic [15:0] REG_RESET = 16'h0000;

	// Sixth flag register fields
	localparam int ADC_PAIR1_DONE_FLAG_BIT = 15;
	localparam int ADC_PAIR0_DONE_FLAG_BIT = 14;
	localparam int COMPARATOR4_FLAG_BIT    = 9;
	localparam int COMPARATOR3_FLAG_BIT    = 8;
	localparam int COMPARATOR2_FLAG_BIT    = 7;
	localparam int PWM_GEN4_FLAG_BIT       = 1;
	localparam int PWM_GEN3_FLAG_BIT       = 0;

	// Seventh flag register fields
	localparam int ADC_PAIR6_DONE_FLAG_BIT = 4;
	localparam int ADC_PAIR5_DONE_FLAG_BIT = 3;
	localparam int ADC_PAIR4_DONE_FLAG_BIT = 2;
	localparam int ADC_PAIR3_DONE_FLAG_BIT = 1;
	localparam int ADC_PAIR2_DONE_FLAG_BIT = 0;

	// Enable register fields
	localparam int ADC_COMPLETE_ENABLE_BIT = 13;
	localparam int UART_TX_ENABLE_BIT      = 12;
	localparam int UART_RX_ENABLE_BIT      = 11;
	localparam int SPI_EVENT_ENABLE_BIT    = 10;
	localparam int SPI_FAULT_ENABLE_BIT    = 9;
	localparam int TIMER3_ENABLE_BIT       = 8;
	localparam int TIMER2_ENABLE_BIT       = 7;
	localparam int COMPARE_CH2_ENABLE_BIT  = 6;
	localparam int CAPTURE_CH2_ENABLE_BIT  = 5;
	localparam int TIMER1_ENABLE_BIT       = 3;
	localparam int COMPARE_CH1_ENABLE_BIT  = 2;
	localparam int CAPTURE_CH1_ENABLE_BIT  = 1;
	localparam int EXT_IRQ0_ENABLE_BIT     = 0;

	// Implemented positions; all others read as zero
	localparam logic [15:0] FLAG_SIX_IMPL = 16'hc383;
	localparam logic [15:0] FLAG_SEVEN_IMPL = 16'h001f;
	localparam logic [15:0] ENABLE_ZERO_IMPL = 16'h3fef;

	// AHB transfer types and sizes used by the slave
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_BYTE    = 3'h0;
	localparam logic [2:0] HSIZE_HALF    = 3'h1;

endpackage : ifeb_pkg

// ============================================================
// Storage cell: one 16-bit register, software write, event set
// ============================================================
module ifeb_reg16
	import ifeb_pkg::*;
#(
	parameter logic [15:0] MASK = 16'hffff
) (
	input  wire logic        clock,
	input  wire logic        rstn,
	input  wire logic [15:0] wr_lanes,
	input  wire logic [15:0] wdata,
	input  wire logic [15:0] set,
	output logic      [15:0] q,
	output logic      [15:0] next_q
);

	// Written lanes take the bus value, event sets win over any clear
	always_comb begin
		next_q = MASK & (((q & ~wr_lanes) | (wdata & wr_lanes)) | set);
	end

	// Storage, zero after power-on reset
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			q <= REG_RESET;
		end else begin
			q <= next_q;
		end
	end

endmodule : ifeb_reg16

`default_nettype wire

/* ifeb_bank.sv */
/*
 * Interrupt flag and enable bank: two flag-status registers and one
 * enable register behind an AHB-Lite slave, with qualified requests.
 * Assumes event, flag and enable inputs come from logic on the same
 * clock, so none of them is synchronised here.
 */
// The AHB-Lite interface to the registers and the address map were chosen for this implementation.
// Notes on behaviour
// R1: Flag six bits 15,14: ADC pairs 1,0.
// R2: Flag six bits 9,8,7: comparators 4,3,2.
// R3: Flag six bits 1,0: PWM generators 4,3.
// R4: Unused positions of all three read zero.
// R5: Flag seven bits 4..0: ADC pairs 6..2.
// R6: Flag reads one once request occurred.
// R7: Implemented bits read/write, zero after reset.
// R8: Enable bits 13,12,11: ADC, UART TX, RX.
// R9: Enable bits 10,9: SPI event, SPI fault.
// R10: Enable bits 8,7,3: timers 3,2,1.
// R11: Enable bits 6,5,2,1: compare/capture channels.
// R12: Enable bit 0: external interrupt zero.
// R13: Enable one permits, zero blocks request.
// R14: Qualified request is flag AND enable.
// R15: Absent sources behave as unused zero bits.
`timescale 1ns/10ps
`default_nettype none

module ifeb_bank
	import ifeb_pkg::*;
#(
	// Per-source presence masks, one bit per register position
	parameter logic [15:0] PRESENT_SIX   = FLAG_SIX_IMPL,
	parameter logic [15:0] PRESENT_SEVEN = FLAG_SEVEN_IMPL,
	parameter logic [15:0] PRESENT_ZERO  = ENABLE_ZERO_IMPL
) (
	input  wire logic        clock,
	input  wire logic        rstn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	// Event pulses that set flags of registers six and seven
	input  wire logic [15:0] event_six,
	input  wire logic [15:0] event_seven,
	// Enables for registers six and seven, held elsewhere
	input  wire logic [15:0] enable_six,
	input  wire logic [15:0] enable_seven,
	// Flags matching the enable register, held elsewhere
	input  wire logic [15:0] flag_zero,
	// Qualified requests toward the priority logic
	output logic      [15:0] request_six,
	output logic      [15:0] request_seven,
	output logic      [15:0] request_zero
);

	// ============================================================
	// Effective masks
	// ============================================================

	// R15: presence masks
	// Absent sources drop out of storage, read-back and requests alike.
	localparam logic [15:0] MASK_SIX   = FLAG_SIX_IMPL & PRESENT_SIX;
	localparam logic [15:0] MASK_SEVEN = FLAG_SEVEN_IMPL & PRESENT_SEVEN;
	localparam logic [15:0] MASK_ZERO  = ENABLE_ZERO_IMPL & PRESENT_ZERO;

	// ============================================================
	// AHB-Lite address phase capture
	// ============================================================

	logic              dp_write;
	logic [ADDR_W-1:0] dp_addr;
	logic [3:0]        dp_strobe;
	logic              ap_take;
	logic [3:0]        ap_strobe;

	// Only non-sequential or sequential transfers with bus ready count
	assign ap_take = hsel & hready & htrans[1];

	// Byte lanes of the transfer, so narrow writes touch only their bytes
	always_comb begin
		unique case (hsize)
			HSIZE_BYTE: ap_strobe = 4'h1 << haddr[1:0];
			HSIZE_HALF: ap_strobe = haddr[1] ? 4'hc : 4'h3;
			default:    ap_strobe = 4'hf;
		endcase
	end

	// Write data phase state, held while hready is low; dp_write cleared when no write is taken, address and lanes loaded on every hready cycle
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			dp_write  <= 1'b0;
			dp_addr   <= '0;
			dp_strobe <= 4'h0;
		end else if (hready) begin
			dp_write  <= ap_take & hwrite;
			dp_addr   <= haddr[ADDR_W-1:0];
			dp_strobe <= ap_strobe;
		end
	end

	// ============================================================
	// Write decode
	// ============================================================

	logic [15:0] lanes;
	logic [15:0] wr_six;
	logic [15:0] wr_seven;
	logic [15:0] wr_zero;
	logic [15:0] wdata;

	// Registers sit in the low half of each word; upper lanes ignored
	assign lanes = {{8{dp_strobe[1]}}, {8{dp_strobe[0]}}};
	assign wdata = hwdata[15:0];

	// R7: software write paths
	always_comb begin
		wr_six   = 16'h0000;
		wr_seven = 16'h0000;
		wr_zero  = 16'h0000;
		if (dp_write) begin
			unique case ({dp_addr[ADDR_W-1:2], 2'b00})
				FLAG_STATUS_SIX_OFS:     wr_six   = lanes;
				FLAG_STATUS_SEVEN_OFS:   wr_seven = lanes;
				ENABLE_CONTROL_ZERO_OFS: wr_zero  = lanes;
				default:                 ;
			endcase
		end
	end

	// ============================================================
	// Registers
	// ============================================================

	logic [15:0] flag_status_six;
	logic [15:0] flag_status_seven;
	logic [15:0] enable_control_zero;
	logic [15:0] next_flag_status_six;
	logic [15:0] next_flag_status_seven;
	logic [15:0] next_enable_control_zero;

	// R1: pair done flags at 15 and 14
	// R2: comparator flags at 9, 8 and 7
	// R3: PWM generator flags at 1 and 0
	// R6: event sets flag, sticky
	// R4: unused bits masked off
	ifeb_reg16 #(
		.MASK (MASK_SIX)
	) u_flag_six (
		.clock    (clock),
		.rstn     (rstn),
		.wr_lanes (wr_six),
		.wdata    (wdata),
		.set      (event_six),
		.q        (flag_status_six),
		.next_q   (next_flag_status_six)
	);

	// R5: pairs six to two
	// R6: event sets flag, sticky
	ifeb_reg16 #(
		.MASK (MASK_SEVEN)
	) u_flag_seven (
		.clock    (clock),
		.rstn     (rstn),
		.wr_lanes (wr_seven),
		.wdata    (wdata),
		.set      (event_seven),
		.q        (flag_status_seven),
		.next_q   (next_flag_status_seven)
	);

	// R8: ADC and UART enables
	// R9: SPI event and fault
	// R10: three timer enables
	// R11: capture/compare enables
	// R12: external interrupt zero
	// Enables have no hardware setter; software alone changes them.
	ifeb_reg16 #(
		.MASK (MASK_ZERO)
	) u_enable_zero (
		.clock    (clock),
		.rstn     (rstn),
		.wr_lanes (wr_zero),
		.wdata    (wdata),
		.set      (16'h0000),
		.q        (enable_control_zero),
		.next_q   (next_enable_control_zero)
	);

	// ============================================================
	// Read path
	// ============================================================

	logic [15:0] rd_value;

	// Next values are read so a write just before a read is seen at once
	always_comb begin
		unique case ({haddr[ADDR_W-1:2], 2'b00})
			FLAG_STATUS_SIX_OFS:     rd_value = next_flag_status_six;
			FLAG_STATUS_SEVEN_OFS:   rd_value = next_flag_status_seven;
			ENABLE_CONTROL_ZERO_OFS: rd_value = next_enable_control_zero;
			default:                 rd_value = 16'h0000;
		endcase
	end

	// R4: upper half reads zero
	// Read data loaded at the address phase edge, zero wait states
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			hrdata <= 32'h0000_0000;
		end else if (ap_take & ~hwrite) begin
			hrdata <= {16'h0000, rd_value};
		end
	end

	// hreadyout low only until the first clock after reset; never errors; unmapped words read zero
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			hreadyout <= 1'b0;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// ============================================================
	// Qualified requests
	// ============================================================

	// R14: flag AND enable
	// R13: enable gates request
	// Registered, so requests trail the flag by one clock.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			request_six   <= 16'h0000;
			request_seven <= 16'h0000;
			request_zero  <= 16'h0000;
		end else begin
			request_six   <= flag_status_six & enable_six;
			request_seven <= flag_status_seven & enable_seven;
			request_zero  <= flag_zero & enable_control_zero;
		end
	end

endmodule : ifeb_bank

`default_nettype wire

/* ifeb_bank_chk.sv */
/*
 * Port checker for the interrupt flag and enable bank.
 * Assumes it is bound into ifeb_bank with the default presence masks.
 */
`timescale 1ns/10ps
`default_nettype none

// ============================================================
// Checker
// ============================================================
module ifeb_bank_chk
	import ifeb_pkg::*;
(
	input wire logic        clock,
	input wire logic        rstn,
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	input wire logic [15:0] event_six,
	input wire logic [15:0] event_seven,
	input wire logic [15:0] enable_six,
	input wire logic [15:0] enable_seven,
	input wire logic [15:0] flag_zero,
	input wire logic [15:0] request_six,
	input wire logic [15:0] request_seven,
	input wire logic [15:0] request_zero
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	// Event then enable held: request two edges on
	sequence s_ev6; event_six[14] && enable_six[14] ##1 enable_six[14]; endsequence
	sequence s_ev7;
		event_seven[4] && enable_seven[4] ##1 enable_seven[4];
	endsequence

	property p_okay; !hresp; endproperty
	property p_ready; $past(rstn) |-> hreadyout; endproperty
	property p_upper; hrdata[31:16] == 16'h0000; endproperty
	property p_m6; (request_six & ~FLAG_SIX_IMPL) == 16'h0000; endproperty
	property p_m7; (request_seven & ~FLAG_SEVEN_IMPL) == 16'h0000; endproperty
	property p_m0; (request_zero & ~ENABLE_ZERO_IMPL) == 16'h0000; endproperty
	property p_and0; (request_zero & ~$past(flag_zero)) == 16'h0000; endproperty
	property p_and6; (request_six & ~$past(enable_six)) == 16'h0000; endproperty
	property p_ev6; s_ev6 |=> request_six[14]; endproperty
	property p_ev7; s_ev7 |=> request_seven[4]; endproperty
	// Read data only moves when a read is taken
	property p_hold;
		!(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata);
	endproperty

	a_okay: assert property (p_okay) else $error("hresp not okay");
	a_ready: assert property (p_ready) else $error("wait state seen");
	a_upper: assert property (p_upper) else $error("upper rdata set");
	a_m6: assert property (p_m6) else $error("unused six request");
	a_m7: assert property (p_m7) else $error("unused seven request");
	a_m0: assert property (p_m0) else $error("unused zero request");
	a_and0: assert property (p_and0) else $error("request without flag");
	a_and6: assert property (p_and6) else $error("request not enabled");
	a_ev6: assert property (p_ev6) else $error("adc pair0 no request");
	a_ev7: assert property (p_ev7) else $error("adc pair6 no request");
	a_hold: assert property (p_hold) else $error("hrdata moved");
endmodule : ifeb_bank_chk

bind ifeb_bank ifeb_bank_chk u_chk (.clock, .rstn, .hsel, .htrans, .hwrite,
	.hready, .hreadyout, .hresp, .hrdata, .event_six, .event_seven,
	.enable_six, .enable_seven, .flag_zero, .request_six, .request_seven,
	.request_zero);

`default_nettype wire

/* ifeb_src.sv */
/*
 * Peripheral event sources: turn a held fire request into one pulse.
 * Assumes fire lines change just after a rising clock edge.
 */
`timescale 1ns/10ps
`default_nettype none

// ============================================================
// Event source model
// ============================================================
module ifeb_src (
	input  wire logic        clock,
	input  wire logic        rstn,
	input  wire logic [15:0] fire_six,
	input  wire logic [15:0] fire_seven,
	output logic      [15:0] event_six,
	output logic      [15:0] event_seven
);
	logic [15:0] last_six, last_seven;

	// Edge detect, so a long fire still gives one event
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			last_six    <= 16'h0000;
			last_seven  <= 16'h0000;
			event_six   <= 16'h0000;
			event_seven <= 16'h0000;
		end else begin
			last_six    <= fire_six;
			last_seven  <= fire_seven;
			event_six   <= fire_six & ~last_six;
			event_seven <= fire_seven & ~last_seven;
		end
	end
endmodule : ifeb_src

`default_nettype wire

/* ifeb_bank_tb.sv */
/*
 * Self-checking bench for the flag and enable bank over AHB-Lite.
 * Assumes a single slave, so hready is the slave's own hreadyout.
 */
`timescale 1ns/10ps
`default_nettype none

// ============================================================
// Bench
// ============================================================
module ifeb_bank_tb
	import ifeb_pkg::*;
;
	logic        clock = 1'h0, rstn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic        hreadyout, hresp;
	logic [15:0] fire_six = 16'h0, fire_seven = 16'h0, flag_zero = 16'h0;
	logic [15:0] enable_six = 16'h0, enable_seven = 16'h0;
	logic [15:0] event_six, event_seven;
	logic [15:0] request_six, request_seven, request_zero;
	int          n_fail = 0, checked = 0;

	ifeb_bank uut (.clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .event_six(event_six), .event_seven(event_seven),
		.enable_six(enable_six), .enable_seven(enable_seven),
		.flag_zero(flag_zero), .request_six(request_six),
		.request_seven(request_seven), .request_zero(request_zero));
	ifeb_src u_src (.clock(clock), .rstn(rstn), .fire_six(fire_six),
		.fire_seven(fire_seven), .event_six(event_six),
		.event_seven(event_seven));

	always #50 clock = ~clock;

	// One single word transfer; waits on hready, no fixed latency
	task automatic bus(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge clock);
		hsel <= 1'h1; htrans <= HTRANS_NONSEQ; hwrite <= w;
		haddr <= {20'h00000, a};
		do @(posedge clock); while (hreadyout !== 1'h1);
		hsel <= 1'h0; htrans <= 2'h0; hwdata <= d;
		do @(posedge clock); while (hreadyout !== 1'h1);
		r = hrdata;
	endtask : bus

	task automatic cmp(input string n, input logic [31:0] e, g);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : cmp

	task automatic end_sim;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_sim

	// Reset values and masked read/write, unmapped slot included
	task automatic t_regs;
		logic [31:0] r;
		logic [15:0] m[4];
		m = '{FLAG_SIX_IMPL, FLAG_SEVEN_IMPL, ENABLE_ZERO_IMPL, 16'h0000};
		for (int i = 0; i < 4; i++) begin
			bus(1'h0, 12'(i * 4), 32'h0, r);
			cmp("reset", 32'h0, r);
			bus(1'h1, 12'(i * 4), 32'hffffffff, r);
			bus(1'h0, 12'(i * 4), 32'h0, r);
			cmp("rw mask", {16'h0000, m[i]}, r);
			bus(1'h1, 12'(i * 4), 32'h0, r);
			bus(1'h0, 12'(i * 4), 32'h0, r);
			cmp("rw clear", 32'h0, r);
		end
	endtask : t_regs

	// Each event position alone; odd passes keep enables off
	task automatic t_flags;
		logic [31:0] r;
		logic [15:0] b, en;
		for (int i = 0; i < 16; i++) begin
			b = 16'h1 << i;
			en = i[0] ? 16'h0000 : 16'hffff;
			enable_six <= en; enable_seven <= en;
			fire_six <= b; fire_seven <= b;
			@(posedge clock);
			fire_six <= 16'h0; fire_seven <= 16'h0;
			bus(1'h0, FLAG_STATUS_SIX_OFS, 32'h0, r);
			cmp("flag six", {16'h0, b & FLAG_SIX_IMPL}, r);
			bus(1'h0, FLAG_STATUS_SEVEN_OFS, 32'h0, r);
			cmp("flag seven", {16'h0, b & FLAG_SEVEN_IMPL}, r);
			cmp("req six", {16'h0, b & en & FLAG_SIX_IMPL},
				{16'h0, request_six});
			cmp("req seven", {16'h0, b & en & FLAG_SEVEN_IMPL},
				{16'h0, request_seven});
			bus(1'h1, FLAG_STATUS_SIX_OFS, 32'h0, r);
			bus(1'h1, FLAG_STATUS_SEVEN_OFS, 32'h0, r);
		end
	endtask : t_flags

	// Walk one enable bit across the enable register
	task automatic t_enables;
		logic [31:0] r;
		logic [15:0] b;
		flag_zero <= 16'hffff;
		for (int i = 0; i < 16; i++) begin
			b = ENABLE_ZERO_IMPL & (16'h1 << i);
			bus(1'h1, ENABLE_CONTROL_ZERO_OFS, 32'h1 << i, r);
			bus(1'h0, ENABLE_CONTROL_ZERO_OFS, 32'h0, r);
			cmp("enable", {16'h0, b}, r);
			cmp("req zero", {16'h0, b}, {16'h0, request_zero});
		end
		flag_zero <= 16'h0000;
		bus(1'h1, ENABLE_CONTROL_ZERO_OFS, 32'hffff, r);
		repeat (3) @(posedge clock);
		cmp("req no flag", 32'h0, {16'h0, request_zero});
	endtask : t_enables

	initial begin
		repeat (10) @(posedge clock);
		rstn <= 1'h1;
		repeat (2) @(posedge clock);
		t_regs;
		t_flags;
		t_enables;
		end_sim;
	end

	// Hang guard, far beyond the few hundred cycles needed
	initial begin
		repeat (20000) @(posedge clock);
		n_fail++;
		end_sim;
	end
endmodule : ifeb_bank_tb

`default_nettype wire
